// *** verilog/rtsce_consts.svh ***
// constants for the tri-speed clock-enable generator
// Function
// - clock-enable behaviour only when attribute set
// - transmit on tx clock, receive on rx clock
// - drive tx and rx client enables
// - while locked, enable high at gigabit, toggles otherwise
// - below gigabit, acknowledge registered one clock
// - at gigabit, acknowledge bypasses register
`ifndef RTSCE_CONSTS_SVH
`define RTSCE_CONSTS_SVH
`define RTSCE_SPEED_10 2'h0
`define RTSCE_SPEED_100 2'h1
`define RTSCE_SPEED_1000 2'h2
`define RTSCE_EN_RESET 1'h0
`define RTSCE_ACK_RESET 1'h0
`endif

// *** verilog/rtsce_pkg.sv ***
// types of the tri-speed clock-enable generator
package rtsce_pkg;
  typedef enum logic [1:0] {
    RTSCE_SPD_10 = 2'b00,
    RTSCE_SPD_100 = 2'b01,
    RTSCE_SPD_1000 = 2'b10
  } rtsce_speed_t;
endpackage

// *** verilog/rtsce_top.sv ***
// tri-speed client clock-enable and transmit acknowledge timing
`timescale 1ns/10ps
`include "rtsce_consts.svh"
module rtsce_top (
  // transmit domain: phy_tx_clock_in and its reset
  input wire logic I_CLK,
  input wire logic I_RST,
  // receive domain: buffered phy_rx_clock_in and its reset
  input wire logic I_PHY_RX_CLOCK_IN,
  input wire logic I_RX_RST,
  // configuration, static
  input wire logic I_USE_CLOCK_ENABLE_ATTR,
  input wire logic [1:0] I_SPEED,
  input wire logic I_CLOCK_LOCKED_IN,
  // internal acknowledge timing from the transmit engine
  input wire logic I_TX_ACK_INT,
  // client side
  output logic O_TX_CLIENT_ENABLE_OUT,
  output logic O_RX_CLIENT_ENABLE_OUT,
  output logic O_TX_ACCEPT_ACK_OUT
);
  // config straps come from outside: two flops each, per domain
  logic [3:0] tx_cfg_s1_q, tx_cfg_s2_q;
  logic [3:0] rx_cfg_s1_q, rx_cfg_s2_q;
  logic tx_gig, rx_gig, tx_cke, rx_cke;
  logic tx_en_q, rx_en_q, ack_reg_q;

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      tx_cfg_s1_q <= 4'h0;
      tx_cfg_s2_q <= 4'h0;
    end else begin
      tx_cfg_s1_q <= {I_CLOCK_LOCKED_IN, I_USE_CLOCK_ENABLE_ATTR, I_SPEED};
      tx_cfg_s2_q <= tx_cfg_s1_q;
    end
  end

  always_ff @(posedge I_PHY_RX_CLOCK_IN or posedge I_RX_RST) begin
    if (I_RX_RST) begin
      rx_cfg_s1_q <= 4'h0;
      rx_cfg_s2_q <= 4'h0;
    end else begin
      rx_cfg_s1_q <= {I_CLOCK_LOCKED_IN, I_USE_CLOCK_ENABLE_ATTR, I_SPEED};
      rx_cfg_s2_q <= rx_cfg_s1_q;
    end
  end

  // without the attribute the enable stays high while locked, as in clock-driven mode
  assign tx_cke = tx_cfg_s2_q[2];
  assign rx_cke = rx_cfg_s2_q[2];

  // transmit speed decode; with the attribute set, every code but gigabit falls to the slow path,
  // so the spare code can never leave the client with a stuck enable
  always_comb begin
    if (!tx_cke) begin
      tx_gig = 1'h1; // attribute off behaves like gigabit
    end else if (tx_cfg_s2_q[1:0] == rtsce_pkg::RTSCE_SPD_1000) begin
      tx_gig = 1'h1;
    end else begin
      tx_gig = 1'h0; // 10, 100 and the spare code
    end
  end

  // receive speed decode, same rules, own synchronised copy of the straps;
  // the two domains may see a speed change a few edges apart
  always_comb begin
    if (!rx_cke) begin
      rx_gig = 1'h1;
    end else if (rx_cfg_s2_q[1:0] == rtsce_pkg::RTSCE_SPD_1000) begin
      rx_gig = 1'h1;
    end else begin
      rx_gig = 1'h0;
    end
  end

  // tx enable lives only in the transmit clock domain
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      tx_en_q <= `RTSCE_EN_RESET;
    end else if (!tx_cfg_s2_q[3]) begin
      tx_en_q <= `RTSCE_EN_RESET; // lock low holds the logic idle
    end else if (tx_gig) begin
      tx_en_q <= 1'h1;
    end else begin
      tx_en_q <= !tx_en_q;
    end
  end

  // rx enable lives only in the receive clock domain
  always_ff @(posedge I_PHY_RX_CLOCK_IN or posedge I_RX_RST) begin
    if (I_RX_RST) begin
      rx_en_q <= `RTSCE_EN_RESET;
    end else if (!rx_cfg_s2_q[3]) begin
      rx_en_q <= `RTSCE_EN_RESET;
    end else if (rx_gig) begin
      rx_en_q <= 1'h1;
    end else begin
      rx_en_q <= !rx_en_q;
    end
  end

  // acknowledge: one stage below gigabit, zero stages at gigabit;
  // the bypass mux is a registered output, so both paths get one flop
  // here and the slow path gets a second one to keep the extra cycle
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      ack_reg_q <= `RTSCE_ACK_RESET;
      O_TX_ACCEPT_ACK_OUT <= `RTSCE_ACK_RESET;
    end else begin
      ack_reg_q <= I_TX_ACK_INT;
      O_TX_ACCEPT_ACK_OUT <= tx_gig ? I_TX_ACK_INT : ack_reg_q;
    end
  end

  assign O_TX_CLIENT_ENABLE_OUT = tx_en_q;
  assign O_RX_CLIENT_ENABLE_OUT = rx_en_q;


  // checks on the enables; each domain is checked on its own clock and
  // reset, since the two clocks share no phase relation
  // enable at gigabit must stand high on every edge
  a_tx_en_gig_high: assert property (@(posedge I_CLK) disable iff (I_RST)
    (tx_cfg_s2_q[3] && tx_gig) |=> tx_en_q)
    else $error("tx enable not high at gigabit");

  // below gigabit the enable flips on every edge while straps hold still
  a_tx_en_slow_toggle: assert property (@(posedge I_CLK) disable iff (I_RST)
    (tx_cfg_s2_q[3] && !tx_gig && $stable(tx_cfg_s2_q)) |=>
    (tx_en_q != $past(tx_en_q)))
    else $error("tx enable not toggling below gigabit");

  a_rx_en_gig_high: assert property (@(posedge I_PHY_RX_CLOCK_IN)
    disable iff (I_RX_RST)
    (rx_cfg_s2_q[3] && rx_gig) |=> rx_en_q)
    else $error("rx enable not high at gigabit");

  a_rx_en_slow_toggle: assert property (@(posedge I_PHY_RX_CLOCK_IN)
    disable iff (I_RX_RST)
    (rx_cfg_s2_q[3] && !rx_gig && $stable(rx_cfg_s2_q)) |=>
    (rx_en_q != $past(rx_en_q)))
    else $error("rx enable not toggling below gigabit");

  // checks on the acknowledge path; the slow path must lag the fast one
  // by exactly one edge, which the client relies on below gigabit
  a_ack_slow_delay: assert property (@(posedge I_CLK) disable iff (I_RST)
    (!tx_gig && $stable(tx_gig)) ##1 !tx_gig |->
    O_TX_ACCEPT_ACK_OUT == $past(I_TX_ACK_INT, 2))
    else $error("slow acknowledge latency wrong");

  a_ack_gig_bypass: assert property (@(posedge I_CLK) disable iff (I_RST)
    tx_gig |=> O_TX_ACCEPT_ACK_OUT == $past(I_TX_ACK_INT))
    else $error("gigabit acknowledge not bypassed");

  // the extra stage must always hold the last internal acknowledge
  a_ack_stage_load: assert property (@(posedge I_CLK) disable iff (I_RST)
    1'h1 |=> ack_reg_q == $past(I_TX_ACK_INT))
    else $error("acknowledge stage not loaded");

  // checks on the strap handling
  a_attr_off_high: assert property (@(posedge I_CLK) disable iff (I_RST)
    (!tx_cke && tx_cfg_s2_q[3]) |=> tx_en_q)
    else $error("enable not high without attribute");

  a_rx_attr_off_high: assert property (@(posedge I_PHY_RX_CLOCK_IN)
    disable iff (I_RX_RST)
    (!rx_cke && rx_cfg_s2_q[3]) |=> rx_en_q)
    else $error("rx enable not high without attribute");

  a_lock_low_idle: assert property (@(posedge I_CLK) disable iff (I_RST)
    !tx_cfg_s2_q[3] |=> !tx_en_q)
    else $error("enable active while unlocked");

  a_rx_lock_idle: assert property (@(posedge I_PHY_RX_CLOCK_IN)
    disable iff (I_RX_RST)
    !rx_cfg_s2_q[3] |=> !rx_en_q)
    else $error("rx enable active while unlocked");

  // the spare speed code must take the slow path
  a_spare_code_slow: assert property (@(posedge I_CLK) disable iff (I_RST)
    (tx_cfg_s2_q[2:0] == 3'h7) |-> !tx_gig)
    else $error("spare speed code not slow");

  // the second synchroniser stage only ever copies the first
  a_tx_sync_stage: assert property (@(posedge I_CLK) disable iff (I_RST)
    1'h1 |=> tx_cfg_s2_q == $past(tx_cfg_s1_q))
    else $error("tx strap synchroniser broken");

  a_rx_sync_stage: assert property (@(posedge I_PHY_RX_CLOCK_IN)
    disable iff (I_RX_RST)
    1'h1 |=> rx_cfg_s2_q == $past(rx_cfg_s1_q))
    else $error("rx strap synchroniser broken");

  // main scenarios to be reached
  c_tx_slow: cover property (@(posedge I_CLK) disable iff (I_RST)
    !tx_gig && tx_en_q ##1 !tx_en_q ##1 tx_en_q);
  c_tx_gig: cover property (@(posedge I_CLK) disable iff (I_RST) tx_gig && tx_en_q [*4]);
  c_ack_slow: cover property (@(posedge I_CLK) disable iff (I_RST)
    !tx_gig && O_TX_ACCEPT_ACK_OUT);
  c_rx_slow: cover property (@(posedge I_PHY_RX_CLOCK_IN) disable iff (I_RX_RST)
    !rx_gig && rx_en_q ##1 !rx_en_q);
  c_lock_idle: cover property (@(posedge I_CLK) disable iff (I_RST)
    !tx_cfg_s2_q[3] ##1 !tx_en_q);
endmodule

// *** tb/rtsce_client.sv ***
// client model that moves only on enabled beats
`timescale 1ns/10ps
module rtsce_client (
  // clocks and enables
  input wire logic i_tx_clk,
  input wire logic i_rx_clk,
  input wire logic i_tx_en,
  input wire logic i_rx_en,
  // beat counts
  output int o_tx_beats,
  output int o_rx_beats
);
  // state holds through disabled cycles, so slow speeds see half the beats
  always @(posedge i_tx_clk) if (i_tx_en) o_tx_beats <= o_tx_beats + 1;
  always @(posedge i_rx_clk) if (i_rx_en) o_rx_beats <= o_rx_beats + 1;
  // forwarded tx clock from a double-rate register pair on tx clock
  logic ddr_hi, ddr_lo, fwd_txc;
  always @(posedge i_tx_clk) ddr_hi <= 1'b1;
  always @(negedge i_tx_clk) ddr_lo <= 1'b0;
  assign fwd_txc = i_tx_clk ? ddr_hi : ddr_lo;
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the tri-speed client enable generator
`timescale 1ns/10ps
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin miscompares++; \
  $display("BAD %s exp %0h got %0h", nm, e, s); end end
module testbench;
  logic I_CLK = 0, I_RST = 1, rx_clk = 0, rx_rst = 1, attr = 1, lock = 1;
  logic ack_int = 0, run = 0, v, ex, tx_en, rx_en, ack, tx_p, rx_p;
  logic [1:0] spd = 2'h2;
  logic q[$];
  int miscompares = 0, n_compared = 0, seed = 33, cyc = 0, lat = 2, kind = 1, b0, tx_b;
  // attr, lock, speed, enable kind (0 low, 1 high, 2 toggle), ack latency
  int md [6][5] = '{'{1,1,0,2,3}, '{1,1,1,2,3}, '{1,1,2,1,2}, '{1,1,3,2,3},
    '{0,1,0,1,2}, '{1,0,2,0,2}};
  always #20 I_CLK = ~I_CLK; // 25 MHz client clock
  // receive clock at the same rate, phase unrelated
  initial begin #7; forever #20 rx_clk = ~rx_clk; end
  rtsce_top dut (.I_CLK(I_CLK), .I_RST(I_RST), .I_PHY_RX_CLOCK_IN(rx_clk),
    .I_RX_RST(rx_rst), .I_USE_CLOCK_ENABLE_ATTR(attr), .I_SPEED(spd),
    .I_CLOCK_LOCKED_IN(lock), .I_TX_ACK_INT(ack_int), .O_TX_CLIENT_ENABLE_OUT(tx_en),
    .O_RX_CLIENT_ENABLE_OUT(rx_en), .O_TX_ACCEPT_ACK_OUT(ack));
  rtsce_client client (.i_tx_clk(I_CLK), .i_rx_clk(rx_clk), .i_tx_en(tx_en),
    .i_rx_en(rx_en), .o_tx_beats(tx_b), .o_rx_beats());
  task automatic report_and_stop();
    if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // random acknowledge timing, each value driven while run is set noted for the monitor
  always @(posedge I_CLK) begin
    cyc++;
    if (cyc == 1000) begin miscompares++; report_and_stop(); end
    v = 1'($random(seed));
    ack_int <= v;
    if (run) q.push_back(v);
  end
  // compare mid-cycle, once the edge's updates have landed
  always @(negedge I_CLK) begin
    if (run) `CHK("tx_en", kind == 2 ? !tx_p : kind == 1, tx_en)
    if (run && q.size() >= lat) begin
      ex = q.pop_front();
      `CHK("ack", ex, ack)
    end
    tx_p = tx_en;
  end
  always @(negedge rx_clk) begin
    if (run) `CHK("rx_en", kind == 2 ? !rx_p : kind == 1, rx_en)
    rx_p = rx_en;
  end
  // each mode settles past the synchronisers before checks start
  initial begin
    repeat (16) @(posedge I_CLK);
    I_RST <= 0;
    rx_rst <= 0;
    for (int m = 0; m < 6; m++) begin
      @(posedge I_CLK);
      attr <= 1'(md[m][0]);
      lock <= 1'(md[m][1]);
      spd <= 2'(md[m][2]);
      kind = md[m][3];
      lat = md[m][4];
      q.delete();
      repeat (5) @(posedge I_CLK);
      #1 run = 1;
      b0 = tx_b;
      repeat (40) @(posedge I_CLK);
      #1 run = 0;
      `CHK("beats", kind == 2 ? 20 : kind * 40, tx_b - b0)
    end
    report_and_stop();
  end
endmodule
